/* File: hw/pss_edge.sv */
// Rising edge detector for a level input
`timescale 1ns/1ps
module pss_edge (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Level in, pulse out
  input  wire logic level,
  output logic      rise
);
  logic prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level;
    end
  end
  assign rise = level & ~prev_q;
endmodule

/* File: hw/pss_irq.sv */
// Sticky event flags, mask and interrupt line
`timescale 1ns/1ps
module pss_irq #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Events and software access
  input  wire logic [W-1:0] evt,
  input  wire logic         rd_clr,
  input  wire logic [W-1:0] mask,
  output logic [W-1:0]      flags,
  output logic              irq
);
  // Set wins over read-clear so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else begin
      flags <= (rd_clr ? '0 : flags) | evt;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((rd_clr ? '0 : flags) | evt) & mask);
    end
  end
endmodule

/* File: hw/pss_pkg.sv */
// Package: constants for the position mode status word block
package pss_pkg;
  // Register byte addresses
  localparam logic [7:0] PSS_ADDR_STATUS  = 8'h00;
  localparam logic [7:0] PSS_ADDR_CTRL    = 8'h04;
  localparam logic [7:0] PSS_ADDR_EVT     = 8'h08;
  localparam logic [7:0] PSS_ADDR_MASK    = 8'h0c;
  localparam logic [7:0] PSS_ADDR_ALARM   = 8'h10;
  // Status word bit positions
  localparam int PSS_B_TLC    = 15;
  localparam int PSS_B_FERR   = 13;
  localparam int PSS_B_ACK    = 12;
  localparam int PSS_B_ILIM   = 11;
  localparam int PSS_B_TRGT   = 10;
  localparam int PSS_B_REMOTE = 9;
  localparam int PSS_B_WARN   = 7;
  // Control register bit positions
  localparam int PSS_C_NEWSP  = 0;
  localparam int PSS_C_HALT   = 1;
  // Alarm codes that clear the following error
  localparam logic [7:0] PSS_ALM_DEVIATION = 8'h10;
  localparam logic [7:0] PSS_ALM_OVERLOAD  = 8'h30;
  // Event bits
  localparam int PSS_EVT_W    = 4;
  localparam int PSS_E_ACK    = 0;
  localparam int PSS_E_TRGT   = 1;
  localparam int PSS_E_FERR   = 2;
  localparam int PSS_E_REFUSE = 3;
  localparam logic [31:0] PSS_RD_ZERO = 32'h0000_0000;
  typedef enum logic [2:0] {
    PSS_IDLE = 3'b001,
    PSS_MOVE = 3'b010,
    PSS_DONE = 3'b100
  } pss_move_t;
endpackage

/* File: hw/pss_top.sv */
// Position mode status word generator with APB register access
`timescale 1ns/1ps
module pss_top
  import pss_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Drive conditions
  input  wire logic        torque_limit_contact,
  input  wire logic        deviation_over,
  input  wire logic        forward_limit_sensor,
  input  wire logic        reverse_limit_sensor,
  input  wire logic        forward_motion_inhibit,
  input  wire logic        reverse_motion_inhibit,
  input  wire logic        soft_limit,
  input  wire logic        mech_limit,
  input  wire logic        op_enabled,
  input  wire logic        stop_in,
  input  wire logic        motor_excited,
  input  wire logic        move_done,
  input  wire logic        move_abort,
  input  wire logic        velocity_zero,
  input  wire logic        init_done,
  input  wire logic        info_present,
  // Outputs
  output logic [15:0]      drive_status_word,
  output logic             start_pulse,
  output logic             irq
);
  logic [1:0]           ctrl_q;
  logic [PSS_EVT_W-1:0] mask_q;
  logic [PSS_EVT_W-1:0] flags;
  logic                 ferr_q;
  logic                 ack_q;
  logic                 trgt_q;
  logic                 remote_q;
  logic                 alarm_code_ok;
  logic                 alarm_clr;
  logic                 newsp_rise;
  logic                 accept;
  logic                 refuse;
  logic                 any_limit;
  logic                 ack_rise;
  logic                 trgt_rise;
  logic                 ferr_rise;
  pss_move_t            mv_q;
  logic                 wr_en;
  logic                 rd_en;
  logic                 hit;
  logic                 sel_status;
  logic                 sel_ctrl;
  logic                 sel_evt;
  logic                 sel_mask;
  logic                 sel_alarm;
  logic [PSS_EVT_W-1:0] evt;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  // One select per register for writes, error and read-clear; the read data case decodes paddr itself
  assign sel_status = (paddr == PSS_ADDR_STATUS);
  assign sel_ctrl   = (paddr == PSS_ADDR_CTRL);
  assign sel_evt    = (paddr == PSS_ADDR_EVT);
  assign sel_mask   = (paddr == PSS_ADDR_MASK);
  assign sel_alarm  = (paddr == PSS_ADDR_ALARM);
  assign hit        = sel_status | sel_ctrl | sel_evt | sel_mask | sel_alarm;
  // Only the two alarm codes that own bit 13 release it
  assign alarm_code_ok = (pwdata[7:0] == PSS_ALM_DEVIATION) |
                         (pwdata[7:0] == PSS_ALM_OVERLOAD);
  assign alarm_clr     = wr_en & sel_alarm & alarm_code_ok;

  // Control register: set-point request and halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 2'h0;
    end else if (wr_en && sel_ctrl) begin
      ctrl_q <= pwdata[1:0];
    end
  end

  // Interrupt mask, same layout as the event register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= '0;
    end else if (wr_en && sel_mask) begin
      mask_q <= pwdata[PSS_EVT_W-1:0];
    end
  end

  pss_edge u_newsp (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (ctrl_q[PSS_C_NEWSP]),
    .rise    (newsp_rise)
  );

  // Request refused while halted, stopped, not enabled or unexcited
  assign refuse = ctrl_q[PSS_C_HALT] | stop_in | ~op_enabled | ~motor_excited;
  assign accept = newsp_rise & ~refuse;

  // Set-point acknowledge handshake
  // A fresh rise is needed; a request held across a disable is not acked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
    end else if (!op_enabled) begin
      ack_q <= 1'b0;
    end else if (!ctrl_q[PSS_C_NEWSP]) begin
      ack_q <= 1'b0;
    end else if (accept) begin
      ack_q <= 1'b1;
    end
  end

  // One-cycle start strobe towards the profile generator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_pulse <= 1'b0;
    end else begin
      start_pulse <= accept;
    end
  end

  // Move tracking; abort returns to idle without completion
  // Abort wins over done when both arrive in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mv_q <= PSS_IDLE;
    end else begin
      case (mv_q)
        PSS_IDLE: if (accept) begin
          mv_q <= PSS_MOVE;
        end
        PSS_MOVE: if (move_abort) begin
          mv_q <= PSS_IDLE;
        end else if (move_done) begin
          mv_q <= PSS_DONE;
        end
        PSS_DONE: if (accept) begin
          mv_q <= PSS_MOVE;
        end
        default: mv_q <= PSS_IDLE;
      endcase
    end
  end

  // Target reached: halt selects zero-velocity meaning
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trgt_q <= 1'b0;
    end else if (ctrl_q[PSS_C_HALT]) begin
      trgt_q <= velocity_zero;
    end else if (accept) begin
      trgt_q <= 1'b0;
    end else if (mv_q == PSS_MOVE && move_abort) begin
      trgt_q <= 1'b0;
    end else if (mv_q == PSS_MOVE && move_done) begin
      trgt_q <= 1'b1;
    end else if (mv_q == PSS_MOVE) begin
      trgt_q <= 1'b0;
    end
  end

  // Following error: sticky until the matching alarm clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ferr_q <= 1'b0;
    end else if (deviation_over) begin
      ferr_q <= 1'b1;
    end else if (alarm_clr) begin
      ferr_q <= 1'b0;
    end
  end

  // Remote latches once initialization is done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remote_q <= 1'b0;
    end else if (init_done) begin
      remote_q <= 1'b1;
    end
  end

  // Any internal limit source raises bit 11
  assign any_limit = forward_limit_sensor | reverse_limit_sensor |
                     forward_motion_inhibit | reverse_motion_inhibit |
                     soft_limit | mech_limit;

  // Status word registered straight to the output
  // Bits 6 to 0 belong to the state machine outside and read 0 here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_status_word <= 16'h0000;
    end else begin
      drive_status_word <= 16'h0000;
      drive_status_word[PSS_B_TLC]    <= torque_limit_contact;
      drive_status_word[PSS_B_FERR]   <= ferr_q;
      drive_status_word[PSS_B_ACK]    <= ack_q;
      drive_status_word[PSS_B_ILIM]   <= any_limit;
      drive_status_word[PSS_B_TRGT]   <= trgt_q;
      drive_status_word[PSS_B_REMOTE] <= remote_q;
      drive_status_word[PSS_B_WARN]   <= info_present;
    end
  end

  pss_edge u_ack (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (ack_q),
    .rise    (ack_rise)
  );

  pss_edge u_trgt (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (trgt_q),
    .rise    (trgt_rise)
  );

  pss_edge u_ferr (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (ferr_q),
    .rise    (ferr_rise)
  );

  // Refused requests are events too, so software sees a lost start
  assign evt = {newsp_rise & refuse, ferr_rise, trgt_rise, ack_rise};

  pss_irq #(
    .W (PSS_EVT_W)
  ) u_irq (
    .pclk    (pclk),
    .presetn (presetn),
    .evt     (evt),
    .rd_clr  (rd_en & sel_evt),
    .mask    (mask_q),
    .flags   (flags),
    .irq     (irq)
  );

  // Zero wait state slave; pready registered so it is high in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & ~penable;
    end
  end

  // Unmapped address answers with an error and no side effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel & ~penable & ~hit;
    end
  end

  // Read data prepared in setup so it is valid throughout access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= PSS_RD_ZERO;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        PSS_ADDR_STATUS: prdata <= {16'h0000, drive_status_word};
        PSS_ADDR_CTRL:   prdata <= {30'h0000_0000, ctrl_q};
        // Events landing at setup are returned, since access clears them
        PSS_ADDR_EVT:    prdata <= {28'h000_0000, flags | evt};
        PSS_ADDR_MASK:   prdata <= {28'h000_0000, mask_q};
        default:         prdata <= PSS_RD_ZERO;
      endcase
    end
  end
endmodule

/* File: tb/position_mode_status_word_test.sv */
// Testbench for the position mode status word block
`timescale 1ns/1ps
module position_mode_status_word_test;
  import pss_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, start_pulse, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] drive_status_word;
  logic torque_limit_contact, deviation_over, op_enabled, stop_in, motor_excited;
  logic move_done, move_abort, velocity_zero, init_done, info_present, e;
  logic [5:0] lim;
  wire forward_limit_sensor = lim[0];
  wire reverse_limit_sensor = lim[1];
  wire forward_motion_inhibit = lim[2];
  wire reverse_motion_inhibit = lim[3];
  wire soft_limit = lim[4];
  wire mech_limit = lim[5];
  int n_mismatch, checks_done;
  pss_top i_dut (.*);
  pss_master i_mst (.*);
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  task print_verdict;
    if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task cmp(string nm, logic [31:0] ex, logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, ex, got);
    end
  endtask
  task wr(logic [7:0] a, logic [31:0] d);
    i_mst.xfer(1, a, d, q, e);
  endtask
  task rd(logic [7:0] a, logic [15:0] m, logic [15:0] ex, string nm);
    repeat (3) @(posedge pclk);
    i_mst.xfer(0, a, 0, q, e);
    cmp(nm, {16'h0, ex}, {16'h0, q[15:0] & m});
  endtask
  task pulse_done;
    @(posedge pclk) move_done <= 1;
    @(posedge pclk) move_done <= 0;
  endtask
  task t_levels;
    rd(PSS_ADDR_STATUS, 16'hffff, 16'h0000, "reset status");
    @(posedge pclk) init_done <= 1;
    rd(PSS_ADDR_STATUS, 16'h0200, 16'h0200, "remote");
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk) lim <= 6'h1 << i;
      rd(PSS_ADDR_STATUS, 16'h0800, 16'h0800, "limit");
    end
    // Bit 15 is the push completion seen by the controller
    @(posedge pclk) {lim, torque_limit_contact, info_present} <= 8'h3;
    rd(PSS_ADDR_STATUS, 16'hff80, 16'h8280, "tlc warn");
    @(posedge pclk) {torque_limit_contact, info_present} <= 2'b00;
    rd(PSS_ADDR_STATUS, 16'h8880, 16'h0000, "levels off");
    wr(8'h40, 32'h0);
    cmp("unmapped", 1, e);
  endtask
  task t_setpoint;
    wr(PSS_ADDR_MASK, 32'h1);
    wr(PSS_ADDR_CTRL, 32'h1);
    rd(PSS_ADDR_STATUS, 16'h1000, 16'h1000, "ack set");
    cmp("irq", 1, irq);
    rd(PSS_ADDR_EVT, 16'h0001, 16'h0001, "ack event");
    rd(PSS_ADDR_EVT, 16'h0001, 16'h0000, "evt cleared");
    cmp("irq off", 0, irq);
    wr(PSS_ADDR_CTRL, 32'h0);
    rd(PSS_ADDR_STATUS, 16'h1000, 16'h0000, "ack drop");
    wr(PSS_ADDR_CTRL, 32'h1);
    @(posedge pclk) op_enabled <= 0;
    rd(PSS_ADDR_STATUS, 16'h1000, 16'h0000, "ack forced");
    @(posedge pclk) op_enabled <= 1;
    for (int i = 0; i < 4; i++) begin
      wr(PSS_ADDR_CTRL, (i == 0) ? 32'h2 : 32'h0);
      @(posedge pclk) {stop_in, op_enabled, motor_excited} <= {i == 1, i != 2, i != 3};
      wr(PSS_ADDR_CTRL, (i == 0) ? 32'h3 : 32'h1);
      rd(PSS_ADDR_STATUS, 16'h1000, 16'h0000, "refused");
      rd(PSS_ADDR_EVT, 16'h0008, 16'h0008, "refuse event");
      @(posedge pclk) {stop_in, op_enabled, motor_excited} <= 3'b011;
    end
    wr(PSS_ADDR_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
  endtask
  task t_target;
    wr(PSS_ADDR_CTRL, 32'h1);
    pulse_done;
    rd(PSS_ADDR_STATUS, 16'h0400, 16'h0400, "target");
    wr(PSS_ADDR_CTRL, 32'h0);
    wr(PSS_ADDR_CTRL, 32'h1);
    rd(PSS_ADDR_STATUS, 16'h0400, 16'h0000, "restart");
    @(posedge pclk) move_abort <= 1;
    @(posedge pclk) move_abort <= 0;
    pulse_done;
    rd(PSS_ADDR_STATUS, 16'h0400, 16'h0000, "abort");
    wr(PSS_ADDR_CTRL, 32'h0);
    wr(PSS_ADDR_CTRL, 32'h1);
    pulse_done;
    rd(PSS_ADDR_STATUS, 16'h0400, 16'h0400, "target again");
    wr(PSS_ADDR_CTRL, 32'h2);
    rd(PSS_ADDR_STATUS, 16'h0400, 16'h0000, "decel");
    @(posedge pclk) velocity_zero <= 1;
    rd(PSS_ADDR_STATUS, 16'h0400, 16'h0400, "halted");
    wr(PSS_ADDR_CTRL, 32'h0);
  endtask
  task t_ferr;
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk) deviation_over <= 1;
      @(posedge pclk) deviation_over <= 0;
      rd(PSS_ADDR_STATUS, 16'h2000, 16'h2000, "ferr held");
      wr(PSS_ADDR_ALARM, 32'h20);
      rd(PSS_ADDR_STATUS, 16'h2000, 16'h2000, "ferr kept");
      wr(PSS_ADDR_ALARM, i ? 32'h30 : 32'h10);
      rd(PSS_ADDR_STATUS, 16'h2000, 16'h0000, "ferr clear");
    end
  endtask
  initial begin
    {presetn, torque_limit_contact, deviation_over, stop_in, lim} = 0;
    {move_done, move_abort, velocity_zero, init_done, info_present} = 0;
    {op_enabled, motor_excited} = 2'b11;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    t_levels;
    t_setpoint;
    t_target;
    t_ferr;
    print_verdict;
  end
  // Run needs some hundreds of cycles
  initial begin
    #200000;
    n_mismatch++;
    print_verdict;
  end
endmodule

/* File: tb/pss_master.sv */
// Controller model: APB master writing control and polling status
`timescale 1ns/1ps
module pss_master (
  // Clock
  input wire logic        pclk,
  // APB
  output logic            psel,
  output logic            penable,
  output logic            pwrite,
  output logic [7:0]      paddr,
  output logic [31:0]     pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr
);
  initial begin
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    // Released lines show no stale value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

/* File: tb/pss_top_checker.sv */
// Checker for the status word outputs
`timescale 1ns/1ps
module pss_top_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Observed signals
  input wire logic        torque_limit_contact,
  input wire logic        deviation_over,
  input wire logic        forward_limit_sensor,
  input wire logic        reverse_limit_sensor,
  input wire logic        forward_motion_inhibit,
  input wire logic        reverse_motion_inhibit,
  input wire logic        soft_limit,
  input wire logic        mech_limit,
  input wire logic        op_enabled,
  input wire logic        init_done,
  input wire logic        info_present,
  input wire logic [15:0] drive_status_word,
  input wire logic        start_pulse,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic lim;
  assign lim = forward_limit_sensor | reverse_limit_sensor | forward_motion_inhibit
             | reverse_motion_inhibit | soft_limit | mech_limit;
  property p_tlc; drive_status_word[15] == $past(torque_limit_contact); endproperty
  a_tlc: assert property (p_tlc) else $error("torque bit wrong");
  property p_ilim; drive_status_word[11] == $past(lim); endproperty
  a_ilim: assert property (p_ilim) else $error("limit bit wrong");
  property p_warn; drive_status_word[7] == $past(info_present); endproperty
  a_warn: assert property (p_warn) else $error("warning bit wrong");
  property p_zero; !drive_status_word[14] && !drive_status_word[8]; endproperty
  a_zero: assert property (p_zero) else $error("unused bits set");
  property p_ack_off; !op_enabled |-> ##2 !drive_status_word[12]; endproperty
  a_ack_off: assert property (p_ack_off) else $error("ack kept while disabled");
  property p_ferr; $rose(deviation_over) |-> ##[1:2] drive_status_word[13]; endproperty
  a_ferr: assert property (p_ferr) else $error("following error not set");
  property p_start; start_pulse |-> ##[0:1] drive_status_word[12]; endproperty
  a_start: assert property (p_start) else $error("start without ack");
  property p_remote; drive_status_word[9] |=> drive_status_word[9]; endproperty
  a_remote: assert property (p_remote) else $error("remote bit dropped");
  c_start: cover property (start_pulse);
  c_irq: cover property (irq);
  c_trgt: cover property (drive_status_word[10]);
endmodule
bind pss_top pss_top_checker i_chk (.*);
